/* File: src/msb_pkg.sv */
// Package with register map, field layout, timing and types of the sequencer block.
package msb_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_AMON_PERIOD = 8'h08;
  localparam logic [7:0] OFF_AMON_CHANS = 8'h0C;
  localparam logic [7:0] OFF_BAL_ENABLE = 8'h10;
  localparam logic [7:0] OFF_BAL_CONFIG = 8'h14;
  localparam logic [7:0] OFF_DEV_FAULT = 8'h18;
  localparam logic [7:0] OFF_SHDN_CAUSE = 8'h1C;
  localparam logic [7:0] OFF_TEMP_RESULT = 8'h20;
  localparam logic [7:0] OFF_TEMP_THRESH = 8'h24;
  localparam logic [7:0] OFF_SYS_FAULT = 8'h28;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CH_DIG_TEMP = 0;
  localparam int CH_ANA_TEMP = 1;
  localparam int CH_REFERENCE = 2;
  localparam int CTRL_OVS_LSB = 16;
  localparam int CTRL_MODMON = 19;
  localparam int CTRL_SQUEEZE = 20;
  localparam int CTRL_START = 24;
  localparam int ST_RUNNING = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_SHDN = 2;
  localparam int ST_TEMP_FLT = 3;
  localparam int CFG_KEEP = 0;
  localparam int CFG_DUR_LSB = 8;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] TEMP_THRESH_RST = 16'hC000;
  localparam logic [15:0] TEMP_RESULT_RST = 16'h0000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TEMP_PERIOD_US = 1000000;
  localparam int unsigned AMON_UNIT_US = 1000;
  localparam int unsigned TEMP_PERIOD_CYC = TEMP_PERIOD_US * CLK_MHZ;
  localparam int unsigned AMON_UNIT_CYC = AMON_UNIT_US * CLK_MHZ;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MSB_IDLE = 2'b00,
    MSB_HOST = 2'b01,
    MSB_ATEMP = 2'b10,
    MSB_AMON = 2'b11
  } msb_state_t;

  typedef struct packed {
    logic [15:0] chans;
    logic [2:0] ovs;
    logic temp_no_avg;
    logic module_mon;
    logic squeeze;
  } msb_adc_cmd_t;

endpackage

/* File: src/msb_ctl.sv */
// Measurement scheduler, thermal shutdown and passive balance control with an APB register file.
`timescale 1ns/1ps
`default_nettype none

module msb_ctl #(
  parameter int unsigned SEC_CYCLES = msb_pkg::TEMP_PERIOD_CYC,
  parameter int unsigned UNIT_CYCLES = msb_pkg::AMON_UNIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output msb_pkg::msb_adc_cmd_t adc_cmd,
  output logic adc_start,
  output logic adc_abort,
  input wire logic adc_done,
  input wire logic [15:0] adc_temp_data,
  input wire logic ext_fault,
  input wire logic trip_a_pin,
  input wire logic trip_b_pin,
  input wire logic wake_pin,
  output logic shutdown,
  output logic power_hold,
  output logic [15:0] balance_drive_output,
  output logic balance_power
);
  import msb_pkg::*;

  initial begin
    if (SEC_CYCLES < 4 || UNIT_CYCLES < 2 || SEC_CYCLES >= 32'h1000_0000 || UNIT_CYCLES >= 32'h1000_0000) begin
      $error("msb_ctl: timer lengths out of range");
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {wake_pin, trip_b_pin, trip_a_pin};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire logic trip_a = pin_s2_q[0];
  wire logic trip_b = pin_s2_q[1];
  wire logic wake = pin_s2_q[2];

  // ----------------------------------------
  // Registers and APB decode
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [7:0] automon_period_q;
  logic [15:0] automon_channel_set_q, balance_enable_q, temp_result_q, temp_thresh_q;
  logic balance_keep_on_fault_q;
  logic [7:0] balance_duration_q;
  logic user_checksum_error_q, int_temp_fault_q, shutdown_q;
  logic [1:0] shutdown_cause_q;
  msb_state_t state_q;

  wire logic acc = psel && penable && pready;
  wire logic wr = acc && pwrite;
  wire logic wr_ctrl = wr && paddr == OFF_CTRL;
  wire logic wr_status = wr && paddr == OFF_STATUS;
  wire logic wr_period = wr && paddr == OFF_AMON_PERIOD;
  wire logic wr_bal = wr && paddr == OFF_BAL_ENABLE;
  wire logic wr_cfg = wr && paddr == OFF_BAL_CONFIG;
  wire logic wr_dfault = wr && paddr == OFF_DEV_FAULT;
  wire logic wr_cause = wr && paddr == OFF_SHDN_CAUSE;
  wire logic host_go = wr_ctrl && pwdata[CTRL_START];
  wire logic fault_now = ext_fault || int_temp_fault_q;
  wire logic bal_block = fault_now && !balance_keep_on_fault_q;
  logic [31:0] rd_mux;
  logic rd_hit;
  wire logic [31:0] status_word = {28'h0, int_temp_fault_q, shutdown_q, state_q == MSB_HOST,
                                   state_q == MSB_AMON};

  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr)
      OFF_CTRL: rd_mux = {7'h0, 1'b0, ctrl_q[23:0]};
      OFF_STATUS: rd_mux = status_word;
      OFF_AMON_PERIOD: rd_mux = {24'h0, automon_period_q};
      OFF_AMON_CHANS: rd_mux = {16'h0, automon_channel_set_q};
      OFF_BAL_ENABLE: rd_mux = {16'h0, balance_enable_q};
      OFF_BAL_CONFIG: rd_mux = {16'h0, balance_duration_q, 7'h0, balance_keep_on_fault_q};
      OFF_DEV_FAULT: rd_mux = {31'h0, user_checksum_error_q};
      OFF_SHDN_CAUSE: rd_mux = {30'h0, shutdown_cause_q};
      OFF_TEMP_RESULT: rd_mux = {16'h0, temp_result_q};
      OFF_TEMP_THRESH: rd_mux = {16'h0, temp_thresh_q};
      OFF_SYS_FAULT: rd_mux = {31'h0, int_temp_fault_q};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle with data captured.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0;
      pslverr <= psel && penable && !pready && !rd_hit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 32'h0;
      automon_channel_set_q <= 16'h0;
      temp_thresh_q <= TEMP_THRESH_RST;
      balance_keep_on_fault_q <= 1'b0;
      balance_duration_q <= 8'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {8'h0, pwdata[23:0]};
      end
      if (wr && paddr == OFF_AMON_CHANS) begin
        automon_channel_set_q <= pwdata[15:0];
      end
      if (wr && paddr == OFF_TEMP_THRESH) begin
        temp_thresh_q <= pwdata[15:0];
      end
      if (wr_cfg) begin
        balance_keep_on_fault_q <= pwdata[CFG_KEEP];
        balance_duration_q <= pwdata[CFG_DUR_LSB +: 8];
      end
    end
  end

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  logic [27:0] sec_cnt_q, unit_cnt_q, bal_cnt_q;
  logic [7:0] amon_cnt_q, bal_sec_q;
  logic temp_pend_q, amon_due_q;
  wire logic sec_tick = sec_cnt_q == 28'(SEC_CYCLES - 1);
  wire logic unit_tick = unit_cnt_q == 28'(UNIT_CYCLES - 1);
  wire logic bal_tick = bal_cnt_q == 28'(SEC_CYCLES - 1);
  wire logic amon_restart = (wr_status && pwdata[ST_RUNNING] && automon_period_q != 8'h0)
                            || (wr_period && pwdata[7:0] != 8'h0 && automon_period_q == 8'h0);
  wire logic amon_on = automon_period_q != 8'h0;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  msb_state_t state_d;
  msb_adc_cmd_t host_cmd, amon_cmd, temp_cmd, cmd_d;
  logic start_d, abort_d;
  logic [15:0] host_chans;
  assign host_chans = pwdata[15:0];
  assign host_cmd = '{chans: host_chans, ovs: pwdata[CTRL_OVS_LSB +: 3], temp_no_avg: 1'b1,
                      module_mon: pwdata[CTRL_MODMON], squeeze: pwdata[CTRL_SQUEEZE]};
  assign amon_cmd = '{chans: automon_channel_set_q, ovs: ctrl_q[CTRL_OVS_LSB +: 3], temp_no_avg: 1'b1,
                      module_mon: ctrl_q[CTRL_MODMON], squeeze: ctrl_q[CTRL_SQUEEZE]};
  assign temp_cmd = '{chans: 16'h0001, ovs: 3'h0, temp_no_avg: 1'b1, module_mon: 1'b0, squeeze: 1'b0};
  wire logic may_start = !shutdown_q;
  wire logic host_take = host_go && may_start && (state_q == MSB_IDLE || state_q == MSB_ATEMP);
  wire logic start_dt = start_d && cmd_d.chans[CH_DIG_TEMP];

  always_comb begin
    state_d = state_q;
    cmd_d = adc_cmd;
    start_d = 1'b0;
    abort_d = 1'b0;
    if (host_take) begin
      // Digital, analog and reference channels ride in the host channel set.
      state_d = MSB_HOST;
      cmd_d = host_cmd;
      start_d = 1'b1;
      abort_d = state_q == MSB_ATEMP;
    end else if (state_q == MSB_IDLE && may_start && amon_on && amon_due_q) begin
      state_d = MSB_AMON;
      cmd_d = amon_cmd;
      start_d = 1'b1;
    end else if (state_q == MSB_IDLE && may_start && temp_pend_q) begin
      state_d = MSB_ATEMP;
      cmd_d = temp_cmd;
      start_d = 1'b1;
    end else if (state_q != MSB_IDLE && adc_done) begin
      state_d = MSB_IDLE;
    end else if (shutdown_q && state_q != MSB_IDLE) begin
      state_d = MSB_IDLE;
      abort_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= MSB_IDLE;
      adc_cmd <= '0;
      adc_start <= 1'b0;
      adc_abort <= 1'b0;
    end else begin
      state_q <= state_d;
      adc_cmd <= cmd_d;
      adc_start <= start_d;
      adc_abort <= abort_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_q <= 28'h0;
      temp_pend_q <= 1'b0;
    end else begin
      sec_cnt_q <= (start_dt || sec_tick) ? 28'h0 : sec_cnt_q + 28'h1;
      if (sec_tick || (abort_d && state_q == MSB_ATEMP && !cmd_d.chans[CH_DIG_TEMP])) begin
        temp_pend_q <= 1'b1;
      end else if (start_dt) begin
        temp_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      automon_period_q <= 8'h0;
      unit_cnt_q <= 28'h0;
      amon_cnt_q <= 8'h0;
      amon_due_q <= 1'b0;
    end else begin
      if (wr_period) begin
        automon_period_q <= pwdata[7:0];
      end
      if (amon_restart || !amon_on) begin
        unit_cnt_q <= 28'h0;
        amon_cnt_q <= 8'h0;
        amon_due_q <= amon_restart;
      end else begin
        unit_cnt_q <= unit_tick ? 28'h0 : unit_cnt_q + 28'h1;
        if (unit_tick && amon_cnt_q + 8'h1 >= automon_period_q) begin
          amon_cnt_q <= 8'h0;
          amon_due_q <= 1'b1;
        end else begin
          if (unit_tick) begin
            amon_cnt_q <= amon_cnt_q + 8'h1;
          end
          if (start_d && state_d == MSB_AMON) begin
            amon_due_q <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Temperature result and fault
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_result_q <= TEMP_RESULT_RST;
      int_temp_fault_q <= 1'b0;
    end else begin
      if (adc_done && state_q != MSB_IDLE && adc_cmd.chans[CH_DIG_TEMP]) begin
        temp_result_q <= adc_temp_data;
      end
      int_temp_fault_q <= temp_result_q > temp_thresh_q;
    end
  end

  // ----------------------------------------
  // Thermal shutdown
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_q <= 1'b0;
      shutdown_cause_q <= 2'h0;
    end else begin
      if (trip_a || trip_b) begin
        shutdown_q <= 1'b1;
      end else if (shutdown_q && wake) begin
        shutdown_q <= 1'b0;
      end
      shutdown_cause_q <= (shutdown_cause_q & ~(wr_cause ? pwdata[1:0] : 2'h0)) | {trip_b, trip_a};
    end
  end

  // ----------------------------------------
  // Passive balancing
  // ----------------------------------------
  logic [15:0] bal_d;
  wire logic bal_expire = balance_duration_q != 8'h0 && bal_tick && bal_sec_q + 8'h1 >= balance_duration_q;
  always_comb begin
    bal_d = balance_enable_q;
    if (bal_block) begin
      bal_d = 16'h0;
    end else if (wr_bal) begin
      bal_d = pwdata[15:0];
    end else if (bal_expire) begin
      bal_d = 16'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      balance_enable_q <= 16'h0;
      bal_cnt_q <= 28'h0;
      bal_sec_q <= 8'h0;
      user_checksum_error_q <= 1'b0;
    end else begin
      balance_enable_q <= bal_d;
      if (wr_bal || balance_enable_q == 16'h0 || bal_expire) begin
        bal_cnt_q <= 28'h0;
        bal_sec_q <= 8'h0;
      end else begin
        bal_cnt_q <= bal_tick ? 28'h0 : bal_cnt_q + 28'h1;
        bal_sec_q <= bal_tick ? bal_sec_q + 8'h1 : bal_sec_q;
      end
      if (bal_d != balance_enable_q) begin
        user_checksum_error_q <= 1'b1;
      end else if (wr_dfault && pwdata[0]) begin
        user_checksum_error_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown <= 1'b0;
      power_hold <= 1'b0;
      balance_drive_output <= 16'h0;
      balance_power <= 1'b0;
    end else begin
      shutdown <= shutdown_q;
      power_hold <= amon_on;
      balance_drive_output <= balance_enable_q;
      balance_power <= |balance_enable_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_drive_follows_enable: assert property (@(posedge clk) disable iff (!rst_n)
    balance_drive_output == $past(balance_enable_q)) else $error("drive differs from enable");
  chk_bal_power_any: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (balance_power == ($past(balance_enable_q) != 16'h0))) else $error("balance power wrong");
  chk_fault_clears_bal: assert property (@(posedge clk) disable iff (!rst_n)
    bal_block |=> balance_enable_q == 16'h0 && ($stable(balance_duration_q) || $past(wr_cfg)))
    else $error("fault did not clear balancing");
  chk_keep_holds_bal: assert property (@(posedge clk) disable iff (!rst_n)
    (balance_keep_on_fault_q && fault_now && !wr_bal && !bal_expire) |=> $stable(balance_enable_q))
    else $error("balancing changed under keep");
  chk_change_sets_cksum: assert property (@(posedge clk) disable iff (!rst_n)
    (balance_enable_q != $past(balance_enable_q)) |-> user_checksum_error_q) else $error("checksum flag missed");
  chk_trip_shuts_down: assert property (@(posedge clk) disable iff (!rst_n)
    (trip_a || trip_b) |=> shutdown_q ##1 shutdown) else $error("trip did not shut down");
  chk_no_self_wake: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(shutdown_q) |-> $past(wake) && !$past(trip_a || trip_b))
    else $error("left shutdown without wake");
  chk_running_only_amon: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(status_word[ST_RUNNING]) |-> adc_start && adc_cmd.chans == $past(automon_channel_set_q))
    else $error("running bit set without auto-monitor start");
  chk_running_cleared_done: assert property (@(posedge clk) disable iff (!rst_n)
    (status_word[ST_RUNNING] && adc_done) |=> !status_word[ST_RUNNING]) else $error("running bit held after done");
  chk_temp_pend_tick: assert property (@(posedge clk) disable iff (!rst_n)
    sec_tick |=> temp_pend_q) else $error("second tick lost");
  chk_preempt_rerun: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == MSB_ATEMP && host_take && !host_cmd.chans[CH_DIG_TEMP]) |=> state_q == MSB_HOST && temp_pend_q
    && adc_abort) else $error("preempted sample not rescheduled");
  chk_fault_compare: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 int_temp_fault_q == ($past(temp_result_q) > $past(temp_thresh_q))) else $error("temp fault stale");

endmodule

`default_nettype wire

/* File: verif/monitor_sequencer_balance_ctl_tb.sv */
// Self-checking testbench of the measurement sequencer and balance control block.
`timescale 1ns/1ps
`default_nettype none
module monitor_sequencer_balance_ctl_tb;
  import msb_pkg::*;
  localparam int SEC = 64;
  localparam int UNIT = 48;
  localparam int LAT = 12;
  logic clk, rst_n, psel, penable, pwrite, adc_done, ext_fault, trip_a_pin, trip_b_pin, wake_pin;
  logic pready, pslverr, adc_start, adc_abort, shutdown, power_hold, balance_power, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] adc_temp_data, balance_drive_output, tdata;
  msb_adc_cmd_t adc_cmd;
  msb_adc_cmd_t cmds[$];
  int starts[$];
  int cyc = 0, cnt = 0, aborts = 0, errors, samples_checked, n, h, a, hidx;

  msb_ctl #(.SEC_CYCLES(SEC), .UNIT_CYCLES(UNIT)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_cmd(adc_cmd), .adc_start(adc_start), .adc_abort(adc_abort), .adc_done(adc_done),
    .adc_temp_data(adc_temp_data), .ext_fault(ext_fault), .trip_a_pin(trip_a_pin), .trip_b_pin(trip_b_pin),
    .wake_pin(wake_pin), .shutdown(shutdown), .power_hold(power_hold),
    .balance_drive_output(balance_drive_output), .balance_power(balance_power));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Converter stand-in and shared tasks
  // ----------------------------------------
  // Every start, including one that replaces an abandoned conversion, finishes LAT cycles later.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    adc_temp_data <= tdata;
    adc_done <= (cnt == 1 && adc_start !== 1'b1);
    if (adc_abort === 1'b1) aborts <= aborts + 1;
    if (adc_start === 1'b1) begin
      starts.push_back(cyc);
      cmds.push_back(adc_cmd);
      cnt <= LAT;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  task results;
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      check("pready", 1'b0, 1'b1);
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask

  task rdchk(input string nm, input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    check(nm, rd, e);
  endtask

  task wait_st(input int cnt_want);
    int k;
    k = 0;
    while (starts.size() < cnt_want && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (k >= 400) begin
      check("adc_start", 1'b0, 1'b1);
      results();
    end
  endtask

  task wait_sd(input logic v);
    int k;
    k = 0;
    while (shutdown !== v && k < 20) begin
      @(posedge clk);
      k++;
    end
    check("shutdown", shutdown, v);
    if (shutdown !== v) begin
      results();
    end
  endtask

  // The start index is taken two edges after the write, before any automatic start can follow.
  task host_conv(input logic [15:0] ch, input logic [2:0] ov);
    n = starts.size();
    wr(OFF_CTRL, {7'h0, 1'b1, 5'h0, ov, ch});
    repeat (2) @(posedge clk);
    check("host start", starts.size() > n, 1'b1);
    hidx = starts.size() - 1;
    repeat (LAT + 3) @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task s_reset;
    check("shutdown rst", shutdown, 1'b0);
    check("drive rst", balance_drive_output, 16'h0000);
    rdchk("thresh", OFF_TEMP_THRESH, 32'h0000C000);
    rdchk("result", OFF_TEMP_RESULT, 32'h00000000);
    apb(1'b0, 8'h4C, 32'h0);
    check("unmapped err", er, 1'b1);
    check("unmapped data", rd, 32'h0);
  endtask

  task s_balance;
    wr(OFF_BAL_ENABLE, 32'h00008001);
    repeat (2) @(posedge clk);
    check("drive", balance_drive_output, 16'h8001);
    check("bal power", balance_power, 1'b1);
    rdchk("cksum set", OFF_DEV_FAULT, 32'h1);
    wr(OFF_DEV_FAULT, 32'h1);
    rdchk("cksum clr", OFF_DEV_FAULT, 32'h0);
    wr(OFF_BAL_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    check("drive off", balance_drive_output, 16'h0000);
    check("bal unpowered", balance_power, 1'b0);
    rdchk("cksum off", OFF_DEV_FAULT, 32'h1);
  endtask

  task s_fault;
    int k;
    wr(OFF_BAL_CONFIG, 32'h00000500);
    wr(OFF_BAL_ENABLE, 32'h000000FF);
    wr(OFF_DEV_FAULT, 32'h1);
    ext_fault <= 1'b1;
    repeat (4) @(posedge clk);
    check("fault clears", balance_drive_output, 16'h0000);
    rdchk("dur kept", OFF_BAL_CONFIG, 32'h00000500);
    rdchk("cksum fault", OFF_DEV_FAULT, 32'h1);
    ext_fault <= 1'b0;
    wr(OFF_BAL_CONFIG, 32'h00000101);
    wr(OFF_BAL_ENABLE, 32'h000000F0);
    ext_fault <= 1'b1;
    repeat (8) @(posedge clk);
    check("keep on", balance_drive_output, 16'h00F0);
    rdchk("cfg kept", OFF_BAL_CONFIG, 32'h00000101);
    ext_fault <= 1'b0;
    wr(OFF_DEV_FAULT, 32'h1);
    k = 0;
    while (balance_drive_output !== 16'h0000 && k < 3 * SEC) begin
      @(posedge clk);
      k++;
    end
    check("expiry", k < 3 * SEC, 1'b1);
    if (k >= 3 * SEC) begin
      results();
    end
    rdchk("cksum expiry", OFF_DEV_FAULT, 32'h1);
    wr(OFF_BAL_CONFIG, 32'h0);
  endtask

  task s_temp;
    tdata = 16'hD000;
    host_conv(16'h0001, 3'd3);
    check("temp chan", cmds[hidx].chans, 16'h0001);
    check("no avg", cmds[hidx].temp_no_avg, 1'b1);
    check("ovs kept", cmds[hidx].ovs, 3'd3);
    check("squeeze off", cmds[hidx].squeeze, 1'b0);
    rdchk("raw result", OFF_TEMP_RESULT, 32'h0000D000);
    rdchk("temp fault", OFF_SYS_FAULT, 32'h1);
    h = starts[hidx];
    n = starts.size();
    wait_st(n + 2);
    check("timer restart", starts[n] - h >= SEC - 2, 1'b1);
    check("auto chan", cmds[n].chans, 16'h0001);
    check("auto ovs", cmds[n].ovs, 3'd0);
    check("one second", starts[n + 1] - starts[n] inside {[SEC - 2:SEC + LAT + 4]}, 1'b1);
    a = aborts;
    tdata = 16'h1000;
    host_conv(16'h0006, 3'd0);
    check("abort", aborts - a, 32'h1);
    check("ana ref chans", cmds[hidx].chans, 16'h0006);
    wait_st(hidx + 2);
    check("rerun chan", cmds[hidx + 1].chans, 16'h0001);
    check("rerun soon", starts[hidx + 1] - starts[hidx] <= LAT + 4, 1'b1);
    repeat (LAT + 3) @(posedge clk);
    rdchk("fault clear", OFF_SYS_FAULT, 32'h0);
  endtask

  task s_automon;
    tdata = 16'hD000;
    wr(OFF_AMON_CHANS, 32'h00000005);
    n = starts.size();
    wr(OFF_AMON_PERIOD, 32'h1);
    wait_st(n + 1);
    check("amon chans", cmds[n].chans, 16'h0005);
    check("stay powered", power_hold, 1'b1);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("running", rd[ST_RUNNING], 1'b1);
    repeat (LAT) @(posedge clk);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("idle between", rd[ST_RUNNING], 1'b0);
    check("fault in amon", rd[ST_TEMP_FLT], 1'b1);
    n = starts.size();
    wr(OFF_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    check("resync", starts.size(), n + 1);
    wr(OFF_AMON_PERIOD, 32'h0);
    repeat (LAT + 3) @(posedge clk);
    rdchk("amon result", OFF_TEMP_RESULT, 32'h0000D000);
    check("unpowered", power_hold, 1'b0);
    tdata = 16'h1000;
    host_conv(16'h0001, 3'd0);
  endtask

  task s_shutdown;
    trip_a_pin <= 1'b1;
    wait_sd(1'b1);
    rdchk("cause a", OFF_SHDN_CAUSE, 32'h1);
    rdchk("status shdn", OFF_STATUS, 32'h00000004);
    trip_a_pin <= 1'b0;
    trip_b_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wake_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wake_pin <= 1'b0;
    check("no wake hot", shutdown, 1'b1);
    rdchk("cause ab", OFF_SHDN_CAUSE, 32'h3);
    trip_b_pin <= 1'b0;
    repeat (8) @(posedge clk);
    check("no self exit", shutdown, 1'b1);
    wake_pin <= 1'b1;
    wait_sd(1'b0);
    wake_pin <= 1'b0;
    wr(OFF_SHDN_CAUSE, 32'h3);
    rdchk("cause clr", OFF_SHDN_CAUSE, 32'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_fault = 1'b0;
    trip_a_pin = 1'b0;
    trip_b_pin = 1'b0;
    wake_pin = 1'b0;
    tdata = 16'h1000;
    errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    s_reset();
    s_balance();
    s_fault();
    s_temp();
    s_automon();
    s_shutdown();
    results();
  end
endmodule
`default_nettype wire
